// ===== hdl/mip_ctrl.sv
//Contract
// R1: software only clears a pending flag, never writes one.
// R2: control registers are rewritten only while the source is quiet.
// R3: with dual-edge on, software sets edge-sense to falling.
// R4: rewriting edge-sense may set the pending flag spuriously.
// R5: global enable 1 permits maskable interrupts, 0 blocks all.
// R6: pending set on request, cleared when acknowledged and vectored.
// R7: accept needs enable, pending, and level above priority floor.
// R8: level 000b disables; 001b to 111b are levels one to seven.
// R9: floor n enables levels above n; 111b blocks all.
// R10: enable, pending, level and floor are independent storage.
// R11: arbitrate at instruction end; string ops suspend mid-way.
// R12: first step reads address zero; chosen pending flag cleared.
// R13: save flags, clear enable, step, stack; stack kept for 32-63.
// R14: push flags and PC, set floor, load PC from vector.
// R15: acknowledge sequence lasts twenty CPU cycles.
// R16: watchdog, osc-stop, voltage set floor 7; others keep it.
// R17: first word: PC top four, floor, low flag byte.
// R18: state saved as four byte-wide writes.
// R19: return instruction pops flags, floor and PC.
// R20: highest level wins; ties by fixed source order.
// R21: specials fixed priority; software interrupts skip arbitration.
// R22: level field sits in bits 2 to 0 with pending flag.
// R23: vector table 256 bytes at base, four bytes per entry.
// R24: fixed vectors lie in 0FFDCh to 0FFFFh.
// R25: hardware set beats software clear in same cycle.
`default_nettype none
module mip_ctrl
  import mip_pkg::*;
#(
  parameter int unsigned N_SRC = NUM_SRC
)
(
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // peripheral requests and control register writes
  input  wire logic [N_SRC-1:0]   src_req,
  input  wire logic [N_SRC-1:0]   ctl_wr,
  input  wire logic [7:0]         ctl_wdata,
  input  wire logic [N_SRC*6-1:0] src_number,
  // cpu core
  input  wire logic               instr_done,
  input  wire logic               instr_suspendable,
  input  wire logic [19:0]        pc_in,
  input  wire logic [19:0]        sp_in,
  input  wire logic [19:0]        vec_base,
  input  wire logic               special_req,
  input  wire logic               special_forces_floor,
  input  wire logic [19:0]        special_vec,
  input  wire logic               sw_int,
  input  wire logic [5:0]         sw_num,
  input  wire logic               ret_int,
  input  wire logic [7:0]         bus_rdata,
  input  wire logic               flg_wr,
  input  wire logic [15:0]        flg_wdata,
  // bus cycles of the sequence
  output logic [19:0]             bus_addr,
  output logic [7:0]              bus_wdata,
  output logic                    bus_rd,
  output logic                    bus_wr,
  // status toward the core
  output logic [15:0]             flg_out,
  output logic [N_SRC-1:0]        pend_out,
  output logic                    seq_busy,
  output logic                    pc_load,
  output logic [19:0]             pc_out
);
  ////////////////////////////////////////////////////////////////////////////
  // per-source control storage
  logic [N_SRC-1:0]       pend;
  logic [N_SRC-1:0]       ack_clr;
  logic [LVL_W-1:0]       lvl_q [N_SRC];
  logic [LVL_W-1:0]       lvl_d [N_SRC];

  genvar g;
  generate
    for (g = 0; g < N_SRC; g++)
    begin : g_src
      // R1: software only clears pending, by writing zero
      mip_pend u_pend (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .req_pulse (src_req[g]),
        .sense_wr  (ctl_wr[g]),
        .sense_new (ctl_wdata[4]),
        .sw_clear  (ctl_wr[g] && !ctl_wdata[3]),
        .ack_clear (ack_clr[g]),
        .pend_q    (pend[g])
      );
    end
  endgenerate

  // R22: level in bits 2..0
  always_comb
  begin
    for (int i = 0; i < N_SRC; i++)
      lvl_d[i] = ctl_wr[i] ? ctl_wdata[2:0] : lvl_q[i];
  end

  // R10: each field its own flop
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      for (int i = 0; i < N_SRC; i++)
        lvl_q[i] <= LVL_OFF;
    else
      for (int i = 0; i < N_SRC; i++)
        lvl_q[i] <= lvl_d[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration
  logic [15:0]            flg_q;
  logic [15:0]            flg_d;
  logic [2:0]             floor_now;
  logic                   win_vld;
  logic [LVL_W-1:0]       win_lvl;
  logic [$clog2(N_SRC)-1:0] win_idx;

  assign floor_now = flg_q[FLG_FLOOR_LSB +: 3];

  // R20: highest level wins, lower index breaks ties
  always_comb
  begin
    win_vld = 1'b0;
    win_lvl = LVL_OFF;
    win_idx = '0;
    for (int i = N_SRC - 1; i >= 0; i--)
    begin
      // R8: level zero never competes
      // R9: strict compare blocks all at floor 111b
      if (pend[i] && (lvl_q[i] != LVL_OFF) && (lvl_q[i] > floor_now)
          && (lvl_q[i] >= win_lvl))
      begin
        win_vld = 1'b1;
        win_lvl = lvl_q[i];
        win_idx = i[$clog2(N_SRC)-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge and return sequencer
  mip_state_e             st_q;
  mip_state_e             st_d;
  logic [4:0]             cnt_q;
  logic [4:0]             cnt_d;
  logic [15:0]            tmp_q;
  logic [15:0]            tmp_d;
  logic [19:0]            pc_q;
  logic [19:0]            pc_d;
  logic [19:0]            sp_q;
  logic [19:0]            sp_d;
  logic [19:0]            vec_q;
  logic [19:0]            vec_d;
  logic [2:0]             new_floor_q;
  logic [2:0]             new_floor_d;
  logic                   keep_stack_q;
  logic                   keep_stack_d;
  logic [15:0]            word0;
  logic [19:0]            addr_d;
  logic [7:0]             wdata_d;
  logic                   rd_d;
  logic                   wr_d;
  logic                   load_d;
  logic                   mask_ok;

  // R17: top PC nibble, floor, low flag byte
  assign word0 = {tmp_q[FLG_FLOOR_LSB +: 4], pc_q[19:16], tmp_q[7:0]};

  // R5: global enable gates the maskable path
  // R7: enable and pending and level above floor
  // R11: taken at instruction end or at a suspendable point
  assign mask_ok = flg_q[FLG_EN_BIT] && win_vld && (instr_done || instr_suspendable);

  always_comb
  begin
    st_d         = st_q;
    cnt_d        = cnt_q;
    tmp_d        = tmp_q;
    pc_d         = pc_q;
    sp_d         = sp_q;
    vec_d        = vec_q;
    new_floor_d  = new_floor_q;
    keep_stack_d = keep_stack_q;
    flg_d        = flg_wr ? flg_wdata : flg_q;
    ack_clr      = '0;
    addr_d       = bus_addr;
    wdata_d      = 8'h00;
    rd_d         = 1'b0;
    wr_d         = 1'b0;
    load_d       = 1'b0;
    if (st_q != MIP_IDLE)
      cnt_d = cnt_q + 5'h01;
    unique case (st_q)
      MIP_IDLE:
      begin
        cnt_d = 5'h00;
        tmp_d = flg_q;
        pc_d  = pc_in;
        sp_d  = sp_in;
        // R21: special first, software bypasses arbitration
        if (special_req)
        begin
          vec_d        = special_vec;
          // R16: watchdog class forces floor 7
          new_floor_d  = special_forces_floor ? FLOOR_SPECIAL : floor_now;
          keep_stack_d = 1'b0;
          st_d         = MIP_INFO;
        end
        else if (sw_int)
        begin
          vec_d        = vec_base + {12'h000, sw_num, 2'b00};
          new_floor_d  = floor_now;
          // R13: numbers 32..63 keep stack select
          keep_stack_d = (sw_num >= SW_KEEP_STACK);
          st_d         = MIP_INFO;
        end
        else if (mask_ok)
        begin
          // R23: four bytes per entry from base
          vec_d        = vec_base + {12'h000, src_number[win_idx*6 +: 6], 2'b00};
          new_floor_d  = win_lvl;
          keep_stack_d = 1'b0;
          st_d         = MIP_INFO;
        end
        else if (ret_int)
        begin
          st_d = MIP_RD0;
        end
      end
      MIP_INFO:
      begin
        // R12: info read at address zero, clear pending
        addr_d = INFO_ADDR;
        rd_d   = 1'b1;
        if (new_floor_d == win_lvl && !special_req && !sw_int && win_vld)
          ack_clr[win_idx] = 1'b1;
        st_d = MIP_FLAGS;
      end
      MIP_FLAGS:
      begin
        // R13: clear enable and step flags; stack flag unless keep_stack_q
        flg_d[FLG_EN_BIT]   = 1'b0;
        flg_d[FLG_STEP_BIT] = 1'b0;
        if (!keep_stack_q)
          flg_d[FLG_STACK_BIT] = 1'b0;
        st_d = MIP_WR0;
      end
      // R18: four byte writes
      // R14: push flags then PC
      MIP_WR0:
      begin
        addr_d  = sp_q - 20'h00002;
        wdata_d = word0[7:0];
        wr_d    = 1'b1;
        st_d    = MIP_WR1;
      end
      MIP_WR1:
      begin
        addr_d  = sp_q - 20'h00001;
        wdata_d = word0[15:8];
        wr_d    = 1'b1;
        st_d    = MIP_WR2;
      end
      MIP_WR2:
      begin
        addr_d  = sp_q - 20'h00004;
        wdata_d = pc_q[7:0];
        wr_d    = 1'b1;
        st_d    = MIP_WR3;
      end
      MIP_WR3:
      begin
        addr_d  = sp_q - 20'h00003;
        wdata_d = pc_q[15:8];
        wr_d    = 1'b1;
        // R14: floor takes accepted level
        flg_d[FLG_FLOOR_LSB +: 3] = new_floor_q;
        st_d    = MIP_VEC;
      end
      MIP_VEC:
      begin
        // R24: fixed vectors come from special_vec
        // three vector bytes read low first, data lands a cycle later
        addr_d = vec_q + {15'h0000, cnt_q - 5'h06};
        rd_d   = 1'b1;
        if (cnt_q == 5'h07)
          pc_d[7:0] = bus_rdata;
        if (cnt_q == 5'h08)
        begin
          pc_d[15:8] = bus_rdata;
          st_d       = MIP_WAIT;
        end
      end
      MIP_WAIT:
      begin
        // top vector nibble arrives in the first wait cycle
        if (cnt_q == 5'h09)
          pc_d[19:16] = bus_rdata[3:0];
        // R15: pad out to the fixed cycle count
        if (cnt_q == 5'(SEQ_CYCLES - 1))
        begin
          load_d = 1'b1;
          st_d   = MIP_IDLE;
        end
      end
      // R19: return pops flag word and PC
      MIP_RD0:
      begin
        addr_d = sp_q;
        rd_d   = 1'b1;
        st_d   = MIP_RD1;
      end
      MIP_RD1:
      begin
        pc_d[7:0] = bus_rdata;
        addr_d    = sp_q + 20'h00001;
        rd_d      = 1'b1;
        st_d      = MIP_RD2;
      end
      MIP_RD2:
      begin
        pc_d[15:8] = bus_rdata;
        addr_d     = sp_q + 20'h00002;
        rd_d       = 1'b1;
        st_d       = MIP_RD3;
      end
      MIP_RD3:
      begin
        tmp_d[7:0] = bus_rdata;
        addr_d     = sp_q + 20'h00003;
        rd_d       = 1'b1;
        st_d       = MIP_IDLE;
        if (cnt_q == 5'h04)
        begin
          pc_d[19:16]                = bus_rdata[3:0];
          flg_d                      = {1'b0, bus_rdata[6:4], 4'h0, tmp_q[7:0]};
          load_d                     = 1'b1;
          st_d                       = MIP_IDLE;
        end
        else
          st_d = MIP_RD3;
      end
      default:
        st_d = MIP_IDLE;
    endcase
  end

  // sequencer registers; outputs all flopped
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q         <= MIP_IDLE;
      cnt_q        <= 5'h00;
      tmp_q        <= FLG_RST;
      pc_q         <= PC_RST;
      sp_q         <= SP_RST;
      vec_q        <= PC_RST;
      new_floor_q  <= 3'h0;
      keep_stack_q <= 1'b0;
      flg_q        <= FLG_RST;
      bus_addr     <= 20'h00000;
      bus_wdata    <= 8'h00;
      bus_rd       <= 1'b0;
      bus_wr       <= 1'b0;
      pc_load      <= 1'b0;
    end
    else
    begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      tmp_q        <= tmp_d;
      pc_q         <= pc_d;
      sp_q         <= sp_d;
      vec_q        <= vec_d;
      new_floor_q  <= new_floor_d;
      keep_stack_q <= keep_stack_d;
      flg_q        <= flg_d;
      bus_addr     <= addr_d;
      bus_wdata    <= wdata_d;
      bus_rd       <= rd_d;
      bus_wr       <= wr_d;
      pc_load      <= load_d;
    end
  end

  // mirror flops so every output is registered
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flg_out  <= FLG_RST;
      pend_out <= '0;
      seq_busy <= 1'b0;
      pc_out   <= PC_RST;
    end
    else
    begin
      flg_out  <= flg_d;
      pend_out <= pend;
      seq_busy <= (st_d != MIP_IDLE);
      pc_out   <= pc_d;
    end
  end
endmodule // mip_ctrl
`default_nettype wire

// ===== inc/mip_pkg.sv
`default_nettype none
package mip_pkg;
  // source count and vector geometry
  localparam int unsigned NUM_SRC        = 8;
  localparam int unsigned LVL_W          = 3;
  localparam logic [2:0]  LVL_OFF        = 3'h0;
  localparam logic [2:0]  FLOOR_BLOCK    = 3'h7;
  localparam logic [2:0]  FLOOR_SPECIAL  = 3'h7;
  localparam logic [19:0] INFO_ADDR      = 20'h00000;
  localparam int unsigned VEC_BYTES      = 4;
  localparam int unsigned VEC_TABLE_SIZE = 256;
  localparam logic [19:0] FIXED_VEC_LO   = 20'h0FFDC;
  localparam logic [19:0] FIXED_VEC_HI   = 20'h0FFFF;
  localparam logic [19:0] VEC_WDT        = 20'h0FFF0;
  localparam logic [19:0] VEC_ADDR_MATCH = 20'h0FFE8;
  localparam logic [19:0] VEC_SINGLE     = 20'h0FFEC;
  // software numbers at or above this keep the stack select flag
  localparam logic [5:0]  SW_KEEP_STACK  = 6'h20;
  // flag word bit positions
  localparam int unsigned FLG_STEP_BIT   = 3;
  localparam int unsigned FLG_EN_BIT     = 6;
  localparam int unsigned FLG_STACK_BIT  = 7;
  localparam int unsigned FLG_FLOOR_LSB  = 12;
  localparam logic [15:0] FLG_RST        = 16'h0000;
  // timing
  localparam int unsigned SEQ_CYCLES_NS  = 200;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SEQ_CYCLES     = SEQ_CYCLES_NS / CLK_PERIOD_NS;
  localparam logic [19:0] SP_RST         = 20'h00000;
  localparam logic [19:0] PC_RST         = 20'h00000;

  // acknowledge and return sequence states
  typedef enum logic [3:0] {
    MIP_IDLE  = 4'b0000,
    MIP_INFO  = 4'b0001,
    MIP_FLAGS = 4'b0010,
    MIP_WR0   = 4'b0011,
    MIP_WR1   = 4'b0100,
    MIP_WR2   = 4'b0101,
    MIP_WR3   = 4'b0110,
    MIP_VEC   = 4'b0111,
    MIP_WAIT  = 4'b1000,
    MIP_RD0   = 4'b1001,
    MIP_RD1   = 4'b1010,
    MIP_RD2   = 4'b1011,
    MIP_RD3   = 4'b1100
  } mip_state_e;
endpackage : mip_pkg
`default_nettype wire

// ===== hdl/mip_pend.sv
`default_nettype none
module mip_pend
  import mip_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // events
  input  wire logic req_pulse,
  input  wire logic sense_wr,
  input  wire logic sense_new,
  input  wire logic sw_clear,
  input  wire logic ack_clear,
  // state
  output logic      pend_q
);
  logic sense_q;
  logic sense_d;
  logic pend_d;
  logic spurious;

  // edge-sense change can look like an edge
  always_comb
  begin
    sense_d  = sense_q;
    spurious = 1'b0;
    if (sense_wr)
    begin
      sense_d = sense_new;
      // R4: spurious set when a rewrite changes edge-sense
      spurious = (sense_new != sense_q);
    end
    pend_d = pend_q;
    // R6: clear on acknowledge
    if (sw_clear || ack_clear)
      pend_d = 1'b0;
    // R25: set beats clear
    if (req_pulse || spurious)
      pend_d = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_q  <= 1'b0;
      sense_q <= 1'b0;
    end
    else
    begin
      pend_q  <= pend_d;
      sense_q <= sense_d;
    end
  end
endmodule // mip_pend
`default_nettype wire

// ===== testbench/mip_ctrl_sva.sv
`default_nettype none
module mip_ctrl_sva
  import mip_pkg::*;
#(
  parameter int unsigned N_SRC = NUM_SRC
)
(
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             resetn,
  // stimulus side
  input wire logic [N_SRC-1:0] src_req,
  input wire logic [N_SRC-1:0] ctl_wr,
  input wire logic             instr_done,
  input wire logic             instr_suspendable,
  input wire logic [19:0]      sp_in,
  input wire logic             special_req,
  input wire logic             special_forces_floor,
  input wire logic             sw_int,
  input wire logic             ret_int,
  // sequencer outputs
  input wire logic [19:0]      bus_addr,
  input wire logic             bus_rd,
  input wire logic             bus_wr,
  input wire logic [15:0]      flg_out,
  input wire logic [N_SRC-1:0] pend_out,
  input wire logic             seq_busy,
  input wire logic             pc_load
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // info read marks the start of every acknowledge
  logic info_rd;
  assign info_rd = bus_rd && (bus_addr == INFO_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // four byte pushes, flag word first
  sequence s_push;
    bus_wr && bus_addr == sp_in - 20'h2 ##1 bus_wr && bus_addr == sp_in - 20'h1 ##1
    bus_wr && bus_addr == sp_in - 20'h4 ##1 bus_wr && bus_addr == sp_in - 20'h3;
  endsequence
  // idle with no non-maskable source waiting
  sequence s_quiet;
    !seq_busy && !special_req && !sw_int;
  endsequence

  property p_gate;
    s_quiet ##0 (!flg_out[FLG_EN_BIT] || flg_out[14:12] == FLOOR_BLOCK) |-> ##2 !info_rd;
  endproperty
  property p_take;
    info_rd |-> $past(instr_done, 2) || $past(instr_suspendable, 2) || $past(special_req, 2)
      || $past(sw_int, 2);
  endproperty
  property p_len;
    info_rd |-> ##[18:20] pc_load;
  endproperty
  property p_push;
    info_rd |-> ##2 s_push;
  endproperty
  property p_flags;
    info_rd |-> ##[1:2] (!flg_out[FLG_EN_BIT] && !flg_out[FLG_STEP_BIT]);
  endproperty
  property p_clear;
    info_rd && $past(pend_out) != '0 |-> ##[0:1] ($past(pend_out) & ~pend_out) != '0;
  endproperty
  // a pending flag never rises without a request or a control write
  property p_rise;
    (pend_out & ~$past(pend_out) & ~$past(src_req, 2) & ~$past(ctl_wr, 2)) == '0;
  endproperty
  property p_ret;
    s_quiet ##0 (ret_int && !flg_out[FLG_EN_BIT]) |-> ##[1:8] pc_load;
  endproperty
  property p_floor7;
    !seq_busy && special_req && special_forces_floor |-> ##[1:21]
      flg_out[14:12] == FLOOR_SPECIAL;
  endproperty

  a_gate: assert property (p_gate) else $error("maskable taken while gated");
  a_take: assert property (p_take) else $error("take without cause");
  a_len: assert property (p_len) else $error("sequence length wrong");
  a_push: assert property (p_push) else $error("stack pushes wrong");
  a_flags: assert property (p_flags) else $error("flags not cleared");
  a_clear: assert property (p_clear) else $error("pending not cleared");
  a_rise: assert property (p_rise) else $error("pending rose alone");
  a_ret: assert property (p_ret) else $error("return too slow");
  a_floor7: assert property (p_floor7) else $error("floor not forced");
endmodule // mip_ctrl_sva

bind mip_ctrl mip_ctrl_sva #(.N_SRC(N_SRC)) mip_ctrl_sva_inst
(
  .ref_clk(ref_clk), .resetn(resetn), .src_req(src_req), .ctl_wr(ctl_wr),
  .instr_done(instr_done), .instr_suspendable(instr_suspendable), .sp_in(sp_in),
  .special_req(special_req), .special_forces_floor(special_forces_floor),
  .sw_int(sw_int), .ret_int(ret_int), .bus_addr(bus_addr), .bus_rd(bus_rd),
  .bus_wr(bus_wr), .flg_out(flg_out), .pend_out(pend_out), .seq_busy(seq_busy),
  .pc_load(pc_load)
);
`default_nettype wire

// ===== testbench/mip_mem_model.sv
`default_nettype none
module mip_mem_model
  import mip_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // bus cycles from the sequencer
  input  wire logic [19:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  output logic [7:0]       bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [27:0] wq[$];
  logic [7:0]  last_q = 8'hA5;

  // memory contents are a fixed hash of the address
  function automatic logic [7:0] rd_byte(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // info and vector reads
  // outside a read the byte toggles so a stale value never looks valid
  always_comb bus_rdata = bus_rd ? rd_byte(bus_addr) : ~last_q;

  // keep last byte and log every write as address and data
  always @(posedge ref_clk)
  begin
    last_q <= bus_rdata;
    if (bus_wr)
      wq.push_back({bus_addr, bus_wdata});
  end
endmodule // mip_mem_model
`default_nettype wire

// ===== testbench/maskable_interrupt_priority_control_test.sv
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module maskable_interrupt_priority_control_test
  import mip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, resetn, instr_done, instr_suspendable, special_req, sw_int;
  logic        special_forces_floor, ret_int, flg_wr, bus_rd, bus_wr, seq_busy, pc_load;
  logic [7:0]  src_req, ctl_wr, ctl_wdata, bus_rdata, bus_wdata, pend_out, req;
  logic [47:0] src_number;
  logic [19:0] pc_in, sp_in, vec_base, special_vec, bus_addr, pc_out;
  logic [15:0] flg_wdata, flg_out, f;
  logic [5:0]  sw_num;
  logic [7:0]  b0, b1, b2, b3;
  integer      seed, fails, n_compared, lv[8], win, best, rot, k;

  mip_ctrl #(.N_SRC(8)) mip_ctrl_inst
  (
    .ref_clk(ref_clk), .resetn(resetn), .src_req(src_req), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .src_number(src_number), .instr_done(instr_done),
    .instr_suspendable(instr_suspendable), .pc_in(pc_in), .sp_in(sp_in),
    .vec_base(vec_base), .special_req(special_req), .special_vec(special_vec),
    .special_forces_floor(special_forces_floor), .sw_int(sw_int), .sw_num(sw_num),
    .ret_int(ret_int), .bus_rdata(bus_rdata), .flg_wr(flg_wr), .flg_wdata(flg_wdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .flg_out(flg_out), .pend_out(pend_out), .seq_busy(seq_busy), .pc_load(pc_load),
    .pc_out(pc_out)
  );
  mip_mem_model mip_mem_model_inst
  (
    .ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_rdata(bus_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // pending written zero, edge sense taken from s
  task automatic ctl(input int i, input logic s, input logic [2:0] l);
    ctl_wr = 8'h01 << i;
    ctl_wdata = {3'h0, s, 1'b0, l};
    tick();
    ctl_wr = 8'h00;
    tick();
  endtask

  task automatic setf(input logic [15:0] v);
    flg_wr = 1'b1;
    flg_wdata = v;
    tick();
    flg_wr = 1'b0;
  endtask

  // bounded wait for the one-cycle vector load; a hang ends the run
  task automatic wait_load(input int lim);
    k = 0;
    while (pc_load !== 1'b1 && k < lim)
    begin
      tick();
      k++;
    end
    if (k == lim)
    begin
      fails++;
      print_verdict();
    end
  endtask

  // check target, saved bytes and updated flags of one acknowledge
  task automatic run_ack(input logic [19:0] va, input logic [2:0] nf, input logic stk);
    logic [15:0] ef;
    logic [27:0] w[4];
    ef = f;
    ef[FLG_EN_BIT] = 1'b0;
    ef[FLG_STEP_BIT] = 1'b0;
    ef[FLG_STACK_BIT] = stk & f[FLG_STACK_BIT];
    ef[14:12] = nf;
    w = '{{sp_in - 20'h2, f[7:0]}, {sp_in - 20'h1, f[15:12], pc_in[19:16]},
          {sp_in - 20'h4, pc_in[7:0]}, {sp_in - 20'h3, pc_in[15:8]}};
    wait_load(40);
    b0 = mip_mem_model_inst.rd_byte(va);
    b1 = mip_mem_model_inst.rd_byte(va + 20'h1);
    b2 = mip_mem_model_inst.rd_byte(va + 20'h2);
    `CHK("pc_out", {b2[3:0], b1, b0}, pc_out)
    `CHK("flags", ef, flg_out)
    for (int j = 0; j < 4; j++)
      `CHK("stack", w[j], mip_mem_model_inst.wq[j])
    mip_mem_model_inst.wq.delete();
    repeat (3) tick();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h36c3;
    fails = 0;
    n_compared = 0;
    {resetn, instr_done, instr_suspendable, special_req, sw_int, ret_int, flg_wr} = '0;
    {src_req, ctl_wr, ctl_wdata, flg_wdata, sw_num} = '0;
    special_forces_floor = 1'b1;
    for (int i = 0; i < 8; i++)
      src_number[i*6 +: 6] = 6'(13 + i);
    pc_in = 20'($random(seed));
    sp_in = 20'h00800;
    vec_base = 20'h04000;
    special_vec = VEC_WDT;
    repeat (12) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    `CHK("flags", FLG_RST, flg_out)
    `CHK("pend", 8'h00, pend_out)
    // distinct rotated levels so the winner is unique
    for (int it = 0; it < 6; it++)
    begin
      rot = {$random(seed)} % 8;
      for (int i = 0; i < 8; i++)
      begin
        lv[i] = (i + rot) % 8;
        ctl(i, 1'b0, 3'(lv[i]));
      end
      f = 16'($random(seed));
      f[15] = 1'b0;
      f[FLG_EN_BIT] = (it != 1);
      if (it == 2)
        f[14:12] = FLOOR_BLOCK;
      setf(f);
      req = 8'($random(seed));
      src_req = req;
      tick();
      src_req = 8'h00;
      tick();
      `CHK("pend", req, pend_out)
      win = -1;
      best = f[14:12];
      for (int i = 0; i < 8; i++)
        if (f[FLG_EN_BIT] && req[i] && lv[i] > best)
        begin
          best = lv[i];
          win = i;
        end
      instr_done = 1'b1;
      tick();
      instr_done = 1'b0;
      if (win < 0)
      begin
        repeat (25) tick();
        `CHK("busy", 1'b0, seq_busy)
      end
      else
      begin
        run_ack(vec_base + 20'(4 * (13 + win)), 3'(best), 1'b0);
        req[win] = 1'b0;
      end
      `CHK("pend", req, pend_out)
      for (int i = 0; i < 8; i++)
        ctl(i, 1'b0, 3'h0);
      `CHK("pend", 8'h00, pend_out)
      $display("test arbitration %0d done", it);
    end
    // set against clear in one cycle, then an edge-sense change
    src_req = 8'h02;
    ctl_wr = 8'h02;
    ctl_wdata = 8'h00;
    tick();
    src_req = 8'h00;
    ctl_wr = 8'h00;
    tick();
    `CHK("pend", 8'h02, pend_out)
    ctl(0, 1'b1, 3'h0);
    `CHK("pend", 8'h03, pend_out)
    ctl(0, 1'b1, 3'h0);
    ctl(1, 1'b0, 3'h0);
    `CHK("pend", 8'h00, pend_out)
    $display("test pending flags done");
    // software numbers either side of the stack-keeping boundary
    for (int n = 31; n < 33; n++)
    begin
      f = 16'h3080 | (16'($random(seed)) & 16'h0F37);
      setf(f);
      sw_num = 6'(n);
      sw_int = 1'b1;
      tick();
      sw_int = 1'b0;
      run_ack(vec_base + 20'(4 * n), 3'h3, n >= 32);
    end
    $display("test software done");
    f = 16'h1040;
    setf(f);
    special_req = 1'b1;
    k = 0;
    while (seq_busy !== 1'b1 && k < 10)
    begin
      tick();
      k++;
    end
    special_req = 1'b0;
    run_ack(special_vec, FLOOR_SPECIAL, 1'b0);
    $display("test special done");
    ret_int = 1'b1;
    tick();
    ret_int = 1'b0;
    wait_load(10);
    `CHK("return", 1'b1, pc_load)
    b0 = mip_mem_model_inst.rd_byte(sp_in);
    b1 = mip_mem_model_inst.rd_byte(sp_in + 20'h1);
    b2 = mip_mem_model_inst.rd_byte(sp_in + 20'h2);
    b3 = mip_mem_model_inst.rd_byte(sp_in + 20'h3);
    `CHK("ret_pc", {b3[3:0], b1, b0}, pc_out)
    `CHK("ret_flags", {1'b0, b3[6:4], 4'h0, b2}, flg_out)
    $display("test return done");
    print_verdict();
  end
endmodule // maskable_interrupt_priority_control_test
`default_nettype wire
